// >>> stat_pkg.sv
// Purpose: shared constants and types for the status groups and error queue
// Assumes: 16-bit status groups, command port driven by the remote-command parser
// Notes:   error descriptions travel as a text index; the formatter owns the strings
package stat_pkg;

  localparam int COND_W      = 16;
  localparam int QUEUE_DEPTH = 20;
  localparam int DESC_W      = 8;
  localparam int SESR_W      = 8;
  // longest description text in characters, enforced by the formatter
  localparam int DESC_MAX_LEN = 255;

  // hardware 1 condition bit positions
  localparam int HW1_UNUSED_15   = 15;
  localparam int HW1_RIB_INT2    = 14;
  localparam int HW1_RIB_INT1    = 13;
  localparam int HW1_DEC_RESULTS = 12;
  localparam int HW1_DEC_LOWLVL  = 11;
  localparam int HW1_DEC_MEAS    = 10;
  localparam int HW1_DEC_ARMED   = 9;
  localparam int HW1_ENC_AUX     = 8;
  localparam int HW1_ENC_INFO    = 7;
  localparam int HW1_COMM_SUM    = 6;
  localparam int HW1_LIMIT       = 5;
  localparam int HW1_SELFTEST    = 4;
  localparam int HW1_OVERPOWER   = 3;
  localparam int HW1_UNUSED_2    = 2;
  localparam int HW1_MIKE_KEYED  = 1;
  localparam int HW1_BATT_LOW    = 0;

  // communication condition bit positions
  localparam int COMM_SER1_SUM   = 9;
  localparam int COMM_SER2_SUM   = 8;
  localparam int COMM_TXDSP_FAIL = 0;

  // standard event status bits that raise a queued error (bits 2..5)
  localparam logic [SESR_W-1:0] SESR_QUEUE_MASK = 8'h3C;

  // reset values of the writable registers
  localparam logic [COND_W-1:0] RISE_RST   = 16'hFFFF;
  localparam logic [COND_W-1:0] FALL_RST   = 16'h0000;
  localparam logic [COND_W-1:0] ENABLE_RST = 16'h0000;

  // fixed queue messages: -350 "Queue overflow", +0 "No error"
  localparam logic signed [15:0] ERRNUM_OVERFLOW = 16'hFEA2;
  localparam logic signed [15:0] ERRNUM_NONE     = 16'h0000;
  localparam logic [DESC_W-1:0]  DESC_NO_ERROR   = 8'h00;
  localparam logic [DESC_W-1:0]  DESC_OVERFLOW   = 8'h01;

  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_RD_COND  = 4'h1,
    OP_RD_RISE  = 4'h2,
    OP_WR_RISE  = 4'h3,
    OP_RD_FALL  = 4'h4,
    OP_WR_FALL  = 4'h5,
    OP_RD_EVENT = 4'h6,
    OP_RD_EN    = 4'h7,
    OP_WR_EN    = 4'h8,
    OP_CLS      = 4'h9,
    OP_ERR_QRY  = 4'hA
  } op_t;

  typedef enum logic [0:0] {
    GRP_COMM = 1'b0,
    GRP_HW1  = 1'b1
  } group_t;

  typedef struct packed {
    op_t               op;
    group_t            grp;
    logic [COND_W-1:0] data;
  } cmd_t;

  typedef struct packed {
    logic signed [15:0] num;
    logic [DESC_W-1:0]  desc;
  } err_entry_t;

endpackage : stat_pkg

// >>> status_group.sv
// Purpose: one status register group: filters, latched events, enable, summary
// Assumes: condition inputs synchronous to the clock
// Notes:   direct_set feeds events for bits that have no condition stage
`timescale 1ns/1ps
module status_group #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] cond,
  input  wire logic [W-1:0] direct_set,
  input  wire logic         wr_rise,
  input  wire logic         wr_fall,
  input  wire logic         wr_enable,
  input  wire logic [W-1:0] wdata,
  input  wire logic         clr_event,
  output logic      [W-1:0] rise_ff,
  output logic      [W-1:0] fall_ff,
  output logic      [W-1:0] enable_ff,
  output logic      [W-1:0] event_ff,
  output logic              summary_ff
);
  import stat_pkg::*;

  logic [W-1:0] prev_ff;
  logic [W-1:0] set_bits;
  logic [W-1:0] nxt_event;
  logic         nxt_summary;

  assign set_bits = (cond & ~prev_ff & rise_ff) | (~cond & prev_ff & fall_ff) | direct_set;
  assign nxt_event = (clr_event ? '0 : event_ff) | set_bits;
  assign nxt_summary = |(nxt_event & enable_ff);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_ff    <= '0;
      event_ff   <= '0;
      summary_ff <= 1'b0;
    end else begin
      prev_ff    <= cond;
      event_ff   <= nxt_event;
      summary_ff <= nxt_summary;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rise_ff <= RISE_RST[W-1:0];
      fall_ff <= FALL_RST[W-1:0];
    end else begin
      if (wr_rise) rise_ff <= wdata;
      if (wr_fall) fall_ff <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_ff <= ENABLE_RST[W-1:0];
    end else if (wr_enable) begin
      enable_ff <= wdata;
    end
  end

endmodule : status_group

// >>> status_queue_top.sv
// Purpose: hardware 1 and communication status groups plus the error queue
// Assumes: one command per cycle from the command parser, answered next cycle
// Notes:   hardware 1 summary drives status byte bit zero; queue has no summary
//
// How it works
// - event register cleared on query or clear-status
// - error queue is a twenty-entry FIFO
// - queue gives no message-available summary
// - event status bits 2..5 rising push error
// - entry is signed number plus description text
// - full queue: newest becomes -350 overflow
// - empty query answers +0 no error
// - each error query pops oldest entry
// - hardware 1 summary drives status bit zero
// - hardware 1 bit 6 is communication summary
// - bits 14, 13 are interface interrupts
// - bits 12..9 are decoder status flags
// - bit 8: both fields of two sent
// - bit 7: one field sent, not generator
// - bit 5 limit exceeded, no condition stage
// - bits 4,3,1,0: selftest, overpower, mike, battery
// - bits 15 and 2 always zero
// - condition readable, filters readable and writable
// - enable register readable and writable
// - communication reaches status byte via enable
// - comm bits 9,8 serial summaries, 0 dsp
`timescale 1ns/1ps
module status_queue_top #(
  parameter int DEPTH = 20
) (
  input  wire logic                  CORE_CLK,
  input  wire logic                  NRST,
  input  wire logic                  CMD_VALID,
  input  stat_pkg::cmd_t             CMD,
  input  wire logic                  RIB_INT2,
  input  wire logic                  RIB_INT1,
  input  wire logic                  DEC_RESULTS,
  input  wire logic                  DEC_LEVEL_LOW,
  input  wire logic                  DEC_MEASURING,
  input  wire logic                  DEC_ARMED,
  input  wire logic                  ENC_TWO_FIELD_MODE,
  input  wire logic                  ENC_FGEN_MODE,
  input  wire logic                  ENC_FIELD_A_SENDING,
  input  wire logic                  ENC_FIELD_B_SENDING,
  input  wire logic                  LIMIT_EXCEEDED,
  input  wire logic                  SELFTEST_FAILED,
  input  wire logic                  OVERPOWER_TRIPPED,
  input  wire logic                  MIKE_KEYED,
  input  wire logic                  BATTERY_LOW,
  input  wire logic                  SER1_SUMMARY,
  input  wire logic                  SER2_SUMMARY,
  input  wire logic                  TXDSP_FAIL,
  input  wire logic [7:0]            SESR,
  input  stat_pkg::err_entry_t       ERR_IN,
  output logic                       RESP_VALID,
  output logic [15:0]                RESP_DATA,
  output logic                       RESP_IS_ERR,
  output stat_pkg::err_entry_t       RESP_ERR,
  output logic                       STB_BIT0,
  output logic [4:0]                 QUEUE_COUNT
);
  import stat_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
  localparam logic [PW:0]   DEPTH_C  = (PW+1)'(DEPTH);

  // command decode
  logic is_comm;
  logic is_hw1;
  logic op_cls;
  logic op_rd_event;
  logic op_err_qry;
  logic wr_rise_c;
  logic wr_fall_c;
  logic wr_en_c;
  logic wr_rise_h;
  logic wr_fall_h;
  logic wr_en_h;
  logic clr_comm;
  logic clr_hw1;

  assign is_comm     = CMD_VALID && (CMD.grp == GRP_COMM);
  assign is_hw1      = CMD_VALID && (CMD.grp == GRP_HW1);
  assign op_cls      = CMD_VALID && (CMD.op == OP_CLS);
  assign op_rd_event = (CMD.op == OP_RD_EVENT);
  assign op_err_qry  = CMD_VALID && (CMD.op == OP_ERR_QRY);
  assign wr_rise_c   = is_comm && (CMD.op == OP_WR_RISE);
  assign wr_fall_c   = is_comm && (CMD.op == OP_WR_FALL);
  assign wr_en_c     = is_comm && (CMD.op == OP_WR_EN);
  assign wr_rise_h   = is_hw1 && (CMD.op == OP_WR_RISE);
  assign wr_fall_h   = is_hw1 && (CMD.op == OP_WR_FALL);
  assign wr_en_h     = is_hw1 && (CMD.op == OP_WR_EN);
  assign clr_comm    = (is_comm && op_rd_event) || op_cls;
  assign clr_hw1     = (is_hw1 && op_rd_event) || op_cls;

  // communication condition word
  logic [COND_W-1:0] comm_cond;
  always_comb begin
    comm_cond = '0;
    comm_cond[COMM_SER1_SUM]   = SER1_SUMMARY;
    comm_cond[COMM_SER2_SUM]   = SER2_SUMMARY;
    comm_cond[COMM_TXDSP_FAIL] = TXDSP_FAIL;
  end

  logic [COND_W-1:0] comm_rise;
  logic [COND_W-1:0] comm_fall;
  logic [COND_W-1:0] comm_en;
  logic [COND_W-1:0] comm_event;
  logic              comm_summary;

  status_group #(.W(COND_W)) u_comm (
    .clk        (CORE_CLK),
    .nrst       (NRST),
    .cond       (comm_cond),
    .direct_set ('0),
    .wr_rise    (wr_rise_c),
    .wr_fall    (wr_fall_c),
    .wr_enable  (wr_en_c),
    .wdata      (CMD.data),
    .clr_event  (clr_comm),
    .rise_ff    (comm_rise),
    .fall_ff    (comm_fall),
    .enable_ff  (comm_en),
    .event_ff   (comm_event),
    .summary_ff (comm_summary)
  );

  // hardware 1 condition word
  logic one_field_sent;
  logic both_fields_sent;
  logic [COND_W-1:0] hw1_cond;
  logic [COND_W-1:0] hw1_direct;
  logic              limit_prev_ff;

  assign both_fields_sent = ENC_TWO_FIELD_MODE && ENC_FIELD_A_SENDING && ENC_FIELD_B_SENDING;
  // single field, never in generator mode
  assign one_field_sent = !ENC_FGEN_MODE &&
                          (ENC_TWO_FIELD_MODE ? (ENC_FIELD_A_SENDING ^ ENC_FIELD_B_SENDING)
                                              : ENC_FIELD_A_SENDING);

  always_comb begin
    hw1_cond = '0;
    hw1_cond[HW1_RIB_INT2]    = RIB_INT2;
    hw1_cond[HW1_RIB_INT1]    = RIB_INT1;
    hw1_cond[HW1_DEC_RESULTS] = DEC_RESULTS;
    hw1_cond[HW1_DEC_LOWLVL]  = DEC_LEVEL_LOW;
    hw1_cond[HW1_DEC_MEAS]    = DEC_MEASURING;
    hw1_cond[HW1_DEC_ARMED]   = DEC_ARMED;
    hw1_cond[HW1_ENC_AUX]     = both_fields_sent;
    hw1_cond[HW1_ENC_INFO]    = one_field_sent;
    hw1_cond[HW1_COMM_SUM]    = comm_summary;
    hw1_cond[HW1_SELFTEST]    = SELFTEST_FAILED;
    hw1_cond[HW1_OVERPOWER]   = OVERPOWER_TRIPPED;
    hw1_cond[HW1_MIKE_KEYED]  = MIKE_KEYED;
    hw1_cond[HW1_BATT_LOW]    = BATTERY_LOW;
    // bits 15 and 2 stay zero
    hw1_cond[HW1_UNUSED_15]   = 1'b0;
    hw1_cond[HW1_UNUSED_2]    = 1'b0;
  end

  always_comb begin
    hw1_direct = '0;
    hw1_direct[HW1_LIMIT] = LIMIT_EXCEEDED && !limit_prev_ff;
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) limit_prev_ff <= 1'b0;
    else       limit_prev_ff <= LIMIT_EXCEEDED;
  end

  logic [COND_W-1:0] hw1_rise;
  logic [COND_W-1:0] hw1_fall;
  logic [COND_W-1:0] hw1_en;
  logic [COND_W-1:0] hw1_event;
  logic              hw1_summary;

  // comm summary gated by hw1 enable bit 6
  status_group #(.W(COND_W)) u_hw1 (
    .clk        (CORE_CLK),
    .nrst       (NRST),
    .cond       (hw1_cond),
    .direct_set (hw1_direct),
    .wr_rise    (wr_rise_h),
    .wr_fall    (wr_fall_h),
    .wr_enable  (wr_en_h),
    .wdata      (CMD.data),
    .clr_event  (clr_hw1),
    .rise_ff    (hw1_rise),
    .fall_ff    (hw1_fall),
    .enable_ff  (hw1_en),
    .event_ff   (hw1_event),
    .summary_ff (hw1_summary)
  );

  // error queue
  err_entry_t        queue_mem [DEPTH];
  logic [PW-1:0]     wr_ptr_ff;
  logic [PW-1:0]     rd_ptr_ff;
  logic [PW:0]       count_ff;
  logic [SESR_W-1:0] sesr_prev_ff;
  logic              push;
  logic              pop;
  logic              q_full;
  logic              q_empty;
  logic              overwrite;
  logic              append;
  logic [PW-1:0]     newest_idx;
  logic [PW-1:0]     nxt_wr_ptr;
  logic [PW-1:0]     nxt_rd_ptr;
  logic [PW:0]       nxt_count;
  err_entry_t        head;
  err_entry_t        overflow_entry;

  // rising bits 2..5 of event status
  assign push     = |(SESR & ~sesr_prev_ff & SESR_QUEUE_MASK);
  assign q_full   = (count_ff == DEPTH_C);
  assign q_empty  = (count_ff == '0);
  assign pop      = op_err_qry && !q_empty;
  // popping frees a slot, so a simultaneous push still fits
  assign append    = push && (!q_full || pop);
  assign overwrite = push && q_full && !pop;
  assign newest_idx = (wr_ptr_ff == '0) ? LAST_IDX : PW'(wr_ptr_ff - 1'b1);
  assign nxt_wr_ptr = (wr_ptr_ff == LAST_IDX) ? '0 : PW'(wr_ptr_ff + 1'b1);
  assign nxt_rd_ptr = (rd_ptr_ff == LAST_IDX) ? '0 : PW'(rd_ptr_ff + 1'b1);
  assign nxt_count  = (PW+1)'(count_ff + (append ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
  assign head       = queue_mem[rd_ptr_ff];
  assign overflow_entry = '{num: ERRNUM_OVERFLOW, desc: DESC_OVERFLOW};

  always_ff @(posedge CORE_CLK) begin
    if (append) queue_mem[wr_ptr_ff] <= ERR_IN;
    else if (overwrite) queue_mem[newest_idx] <= overflow_entry;
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      count_ff     <= '0;
      sesr_prev_ff <= '0;
    end else begin
      if (append) wr_ptr_ff <= nxt_wr_ptr;
      if (pop)    rd_ptr_ff <= nxt_rd_ptr;
      count_ff     <= nxt_count;
      sesr_prev_ff <= SESR;
    end
  end

  // answer selection
  logic        qry_valid;
  logic [15:0] grp_data;
  logic [15:0] comm_data;
  logic [15:0] hw1_data;
  err_entry_t  nxt_err;

  function automatic logic [15:0] pick(input op_t op, input logic [15:0] c, input logic [15:0] r,
                                       input logic [15:0] f, input logic [15:0] e, input logic [15:0] n);
    case (op)
      OP_RD_COND:  pick = c;
      OP_RD_RISE:  pick = r;
      OP_RD_FALL:  pick = f;
      OP_RD_EVENT: pick = e;
      OP_RD_EN:    pick = n;
      default:     pick = '0;
    endcase
  endfunction : pick

  assign comm_data = pick(CMD.op, comm_cond, comm_rise, comm_fall, comm_event, comm_en);
  assign hw1_data  = pick(CMD.op, hw1_cond, hw1_rise, hw1_fall, hw1_event, hw1_en);
  assign grp_data  = (CMD.grp == GRP_HW1) ? hw1_data : comm_data;
  assign qry_valid = CMD_VALID && (CMD.op inside {OP_RD_COND, OP_RD_RISE, OP_RD_FALL,
                                                  OP_RD_EVENT, OP_RD_EN, OP_ERR_QRY});
  assign nxt_err = q_empty ? '{num: ERRNUM_NONE, desc: DESC_NO_ERROR} : head;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RESP_VALID  <= 1'b0;
      RESP_DATA   <= '0;
      RESP_IS_ERR <= 1'b0;
      RESP_ERR    <= '0;
    end else begin
      RESP_VALID  <= qry_valid;
      RESP_DATA   <= op_err_qry ? 16'h0000 : grp_data;
      RESP_IS_ERR <= op_err_qry;
      RESP_ERR    <= op_err_qry ? nxt_err : '0;
    end
  end

  // status byte bit zero; no queue summary exists
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      STB_BIT0    <= 1'b0;
      QUEUE_COUNT <= '0;
    end else begin
      STB_BIT0    <= hw1_summary;
      QUEUE_COUNT <= 5'(nxt_count);
    end
  end

endmodule : status_queue_top

// >>> status_queue_sva.sv
// Purpose: port-level checks on the status groups and the error queue
// Assumes: one command per cycle, answers one cycle after the taking edge
// Notes:   a push is an SESR bit 2..5 rise against the previous edge
`timescale 1ns/1ps
module status_queue_sva #(
  parameter int DEPTH = 20
) (
  input wire logic           CORE_CLK,
  input wire logic           NRST,
  input wire logic           CMD_VALID,
  input stat_pkg::cmd_t      CMD,
  input wire logic [7:0]     SESR,
  input wire logic           RESP_VALID,
  input wire logic           RESP_IS_ERR,
  input stat_pkg::err_entry_t RESP_ERR,
  input wire logic           STB_BIT0,
  input wire logic [4:0]     QUEUE_COUNT
);
  import stat_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic [7:0] sesr_ff;
  // starts from 0 like the design's edge detector
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) sesr_ff <= 8'h00;
    else sesr_ff <= SESR;
  end
  wire push  = |(SESR & ~sesr_ff & SESR_QUEUE_MASK);
  wire pop   = CMD_VALID && CMD.op == OP_ERR_QRY;
  wire rd_op = CMD_VALID && CMD.op inside {OP_RD_COND, OP_RD_RISE, OP_RD_FALL, OP_RD_EVENT, OP_RD_EN, OP_ERR_QRY};
  sequence mask_off_s;
    CMD_VALID && CMD.op == OP_WR_EN && CMD.grp == GRP_HW1 && CMD.data == 16'h0000;
  endsequence
  sequence stb_quiet_s;
    ##3 !STB_BIT0;
  endsequence
  resp_given_a: assert property (rd_op |=> RESP_VALID) else $error("read without answer");
  resp_none_a: assert property (!rd_op |=> !RESP_VALID) else $error("answer without read");
  err_kind_a: assert property (pop |=> RESP_IS_ERR) else $error("error query not flagged");
  empty_ans_a: assert property (pop && QUEUE_COUNT == 5'h00 && !push
    |=> RESP_ERR.num == 16'sh0000 && RESP_ERR.desc == DESC_NO_ERROR) else $error("empty answer wrong");
  depth_cap_a: assert property (QUEUE_COUNT <= DEPTH) else $error("queue above depth");
  push_grow_a: assert property (push && !pop && QUEUE_COUNT < DEPTH
    |=> QUEUE_COUNT == $past(QUEUE_COUNT) + 5'h01) else $error("push did not count");
  full_hold_a: assert property (push && !pop && QUEUE_COUNT == DEPTH |=> QUEUE_COUNT == DEPTH)
    else $error("overflow changed count");
  pop_shrink_a: assert property (pop && !push && QUEUE_COUNT != 5'h00
    |=> QUEUE_COUNT == $past(QUEUE_COUNT) - 5'h01) else $error("pop did not count");
  stb_masked_a: assert property (mask_off_s |-> stb_quiet_s) else $error("masked summary reached bit 0");
endmodule : status_queue_sva
bind status_queue_top status_queue_sva #(.DEPTH(DEPTH)) u_status_queue_sva (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .CMD_VALID(CMD_VALID), .CMD(CMD), .SESR(SESR), .RESP_VALID(RESP_VALID), .RESP_IS_ERR(RESP_IS_ERR),
  .RESP_ERR(RESP_ERR), .STB_BIT0(STB_BIT0), .QUEUE_COUNT(QUEUE_COUNT));

// >>> cmd_controller.sv
// Purpose: remote controller model issuing one command and taking its answer
// Assumes: answer sampled in the cycle after the taking edge
// Notes:   data lines show the inverse once released
`timescale 1ns/1ps
module cmd_controller (
  input  wire logic           clk,
  output logic                cmd_valid,
  output stat_pkg::cmd_t      cmd,
  input  wire logic           resp_valid,
  input  wire logic [15:0]    resp_data,
  input  stat_pkg::err_entry_t resp_err
);
  import stat_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic issue(input op_t op, input group_t grp, input logic [15:0] data,
                       output logic rv, output logic [15:0] rd, output err_entry_t re);
    @(posedge clk);
    #2;
    cmd_valid = 1'b1;
    cmd = '{op: op, grp: grp, data: data};
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    cmd.data = ~data;
    rv = resp_valid;
    rd = resp_data;
    re.num = resp_err.num;
    re.desc = resp_err.desc;
  endtask : issue
endmodule : cmd_controller

// >>> status_register_group_error_queue_test.sv
// Purpose: self-checking bench for the status groups and the error queue
// Assumes: controller model issues one command at a time
// Notes:   register expectations come from the bench model
`timescale 1ns/1ps
module status_register_group_error_queue_test;
  import stat_pkg::*;
  localparam int DEPTH = 20;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid, resp_valid, resp_is_err, stb, rv;
  cmd_t        cmd;
  logic [17:0] pins = '0;
  logic [7:0]  sesr = 8'h00;
  err_entry_t  err_in = '0;
  err_entry_t  resp_err, re;
  logic [15:0] resp_data, rd;
  logic [4:0]  queue_count;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [15:0] seed = 16'hD0D6;
  logic [15:0] regs [2][3];
  err_entry_t  q [$];
  op_t         wop [3] = '{OP_WR_RISE, OP_WR_FALL, OP_WR_EN};
  op_t         rop [3] = '{OP_RD_RISE, OP_RD_FALL, OP_RD_EN};
  status_queue_top #(.DEPTH(DEPTH)) u_status_queue_top (.CORE_CLK(clk), .NRST(nrst), .CMD_VALID(cmd_valid),
    .CMD(cmd), .RIB_INT2(pins[17]), .RIB_INT1(pins[16]), .DEC_RESULTS(pins[15]), .DEC_LEVEL_LOW(pins[14]),
    .DEC_MEASURING(pins[13]), .DEC_ARMED(pins[12]), .ENC_TWO_FIELD_MODE(pins[11]), .ENC_FGEN_MODE(pins[10]),
    .ENC_FIELD_A_SENDING(pins[9]), .ENC_FIELD_B_SENDING(pins[8]), .LIMIT_EXCEEDED(pins[7]),
    .SELFTEST_FAILED(pins[6]), .OVERPOWER_TRIPPED(pins[5]), .MIKE_KEYED(pins[4]), .BATTERY_LOW(pins[3]),
    .SER1_SUMMARY(pins[2]), .SER2_SUMMARY(pins[1]), .TXDSP_FAIL(pins[0]), .SESR(sesr), .ERR_IN(err_in),
    .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .RESP_IS_ERR(resp_is_err), .RESP_ERR(resp_err),
    .STB_BIT0(stb), .QUEUE_COUNT(queue_count));
  cmd_controller u_cmd_controller (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_err(resp_err));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd
  function automatic logic [15:0] hw1_exp(input logic [17:0] p, input logic comm_sum);
    logic [15:0] c;
    c = 16'h0000;
    c[14:9] = p[17:12];
    c[8] = p[11] & p[9] & p[8];
    c[7] = !p[10] & (p[11] ? p[9] ^ p[8] : p[9]);
    c[6] = comm_sum;
    c[4:3] = p[6:5];
    c[1:0] = p[4:3];
    return c;
  endfunction : hw1_exp
  task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t word exp %h got %h", $time, exp, got);
    end
  endtask : chk_word
  task automatic chk_err(input err_entry_t exp, input err_entry_t got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t entry exp %h got %h", $time, exp, got);
    end
  endtask : chk_err
  task automatic cmdo(input op_t op, input group_t g, input logic [15:0] d);
    u_cmd_controller.issue(op, g, d, rv, rd, re);
  endtask : cmdo
  task automatic rdx(input op_t op, input group_t g, input logic [15:0] exp);
    cmdo(op, g, 16'h0000);
    chk_word(16'h0001, {15'h0000, rv});
    chk_word(exp, rd);
  endtask : rdx
  task automatic wrm(input int k, input group_t g, input logic [15:0] d);
    cmdo(wop[k], g, d);
    regs[g][k] = d;
  endtask : wrm
  task automatic setp(input logic [17:0] v, input int n);
    @(posedge clk);
    #2;
    pins = v;
    repeat (n) @(posedge clk);
    #2;
  endtask : setp
  task automatic conclude();
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    int i;
    int b;
    logic [15:0] r;
    err_entry_t e;
    repeat (16) @(posedge clk);
    #2;
    nrst = 1'b1;
    for (int g = 0; g < 2; g++) begin
      regs[g] = '{RISE_RST, FALL_RST, ENABLE_RST};
      for (int k = 0; k < 3; k++) begin
        rdx(rop[k], group_t'(g), regs[g][k]);
      end
      rdx(OP_RD_EVENT, group_t'(g), 16'h0000);
    end
    cmdo(OP_NONE, GRP_HW1, 16'h1234);
    chk_word(16'h0000, {15'h0000, rv});
    for (i = 0; i < 8; i++) begin
      r = rnd();
      setp({r[1:0], r}, 3);
      rdx(OP_RD_COND, GRP_HW1, hw1_exp(pins, 1'b0));
      rdx(OP_RD_COND, GRP_COMM, {6'h00, pins[2:1], 7'h00, pins[0]});
    end
    setp(18'h00000, 3);
    cmdo(OP_CLS, GRP_COMM, 16'h0000);
    wrm(0, GRP_HW1, 16'h0001);
    wrm(1, GRP_HW1, 16'h0002);
    setp(18'h00018, 3);
    rdx(OP_RD_EVENT, GRP_HW1, 16'h0001);
    rdx(OP_RD_EVENT, GRP_HW1, 16'h0000);
    setp(18'h00000, 3);
    rdx(OP_RD_EVENT, GRP_HW1, 16'h0002);
    setp(18'h00080, 3);
    rdx(OP_RD_EVENT, GRP_HW1, 16'h0020);
    setp(18'h00008, 3);
    cmdo(OP_CLS, GRP_HW1, 16'h0000);
    rdx(OP_RD_EVENT, GRP_HW1, 16'h0000);
    wrm(0, GRP_HW1, 16'hFFFF);
    wrm(2, GRP_HW1, 16'h0001);
    setp(18'h00000, 3);
    setp(18'h00008, 8);
    chk_word(16'h0001, {15'h0000, stb});
    wrm(2, GRP_HW1, 16'h0000);
    setp(18'h00008, 4);
    chk_word(16'h0000, {15'h0000, stb});
    wrm(2, GRP_COMM, 16'h0001);
    setp(18'h00009, 8);
    chk_word(16'h0000, {15'h0000, stb});
    rdx(OP_RD_COND, GRP_HW1, hw1_exp(pins, 1'b1));
    // comm event latched by the dsp fail rise; the query also clears it
    rdx(OP_RD_EVENT, GRP_COMM, 16'h0001);
    rdx(OP_RD_EVENT, GRP_COMM, 16'h0000);
    wrm(2, GRP_HW1, 16'h0040);
    setp(18'h00009, 4);
    chk_word(16'h0001, {15'h0000, stb});
    // bit 6 rise must not queue; 22 real pushes overrun the depth by two
    for (i = 0; i < 23; i++) begin
      b = (i == 0) ? 6 : 2 + i % 4;
      r = rnd();
      e = '{r, r[15:8]};
      @(posedge clk);
      #2;
      sesr[b] = 1'b1;
      err_in = e;
      @(posedge clk);
      #2;
      sesr[b] = 1'b0;
      err_in = '{~r, ~r[15:8]};
      if (b != 6) begin
        if (q.size() < DEPTH) q.push_back(e);
        else q[$] = '{-16'sd350, DESC_OVERFLOW};
      end
      chk_word(16'(q.size()), 16'(queue_count));
    end
    // full queue must not hold bit 0 up once the group events are gone
    cmdo(OP_CLS, GRP_COMM, 16'h0000);
    setp(18'h00009, 4);
    chk_word(16'h0000, {15'h0000, stb});
    chk_word(16'(DEPTH), 16'(queue_count));
    for (i = 0; i < 21; i++) begin
      cmdo(OP_ERR_QRY, GRP_COMM, 16'h0000);
      if (q.size() != 0) begin
        e = q.pop_front();
      end else begin
        e = '{16'sh0000, DESC_NO_ERROR};
      end
      chk_err(e, re);
    end
    for (i = 0; i < 12; i++) begin
      b = i % 3;
      wrm(b, group_t'(i / 3 % 2), rnd());
      rdx(rop[b], group_t'(i / 3 % 2), regs[i / 3 % 2][b]);
    end
    conclude();
  end
endmodule : status_register_group_error_queue_test
